// ### include/fxs_cfg.svh
// Constants of the float exception and status unit.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FXS_CFG_SVH
`define FXS_CFG_SVH
// Behaviour
// - Negative flag (bit 3) follows the sign of the last result.
// - Zero flag (bit 2) is set only when the last result is zero.
// - Overflow flag (bit 1) is set only on exponent overflow.
// - Carry flag (bit 0) is set only by a carry out in conversion to integer.
// - Every float trap goes through the one vector at octal 244.
// - Cause register holds codes 2,4,6,8,10,12 for the six exceptions.
// - Exception pc register catches the faulting instruction address.
// - Divide by zero and bad opcode always update; the other four only when enabled.
// - A disabled one of the four leaves cause and pc registers unchanged.
// - Global interrupt disable does not stop cause and pc updates.
// - An op without exception leaves cause and pc registers unchanged.
// - No write path reaches the cause and pc registers; reads only.
// - Eight addressing modes; mode 0 selects a float accumulator.
// - Auto step is 4 in single and octal 10 in double; the deferred auto modes step 2.
// - Mode 0 with accumulator 6 or 7 traps as a bad opcode.
// - Modes other than 0 with a memory operand allow accumulators 0 to 3 only.
// - Most significant word sits at the lowest address.
// - Exponent 0 is exact zero; negative zero from memory traps on arith ops when its enable is set.
// - Zero divisor traps; zero dividend gives an exact zero.
// - Fractions are 24 or 56 bits, two guard bits kept.
// - Round adds one lsb when the first dropped bit is 1.
// - Enabled overflow or underflow stores the low eight exponent bits.
// - Global disable bit 14 suppresses every float trap.
// - Error bit 15 is set on qualifying exceptions, cleared only by load.
`define FXS_B_ERR     15
`define FXS_B_IDIS    14
`define FXS_B_UVEN    11
`define FXS_B_UNEN    10
`define FXS_B_OVEN    9
`define FXS_B_ICEN    8
`define FXS_B_DBL     7
`define FXS_B_CHOP    5
`define FXS_B_NEG     3
`define FXS_B_ZERO    2
`define FXS_B_OVF     1
`define FXS_B_CARRY   0
`define FXS_STAT_WMASK 16'hcfef
`define FXS_STAT_RST   16'h0000
`define FXS_CAUSE_RST  4'h0
`define FXS_PC_RST     16'h0000
`define FXS_CODE_OPC   4'h2
`define FXS_CODE_DIV0  4'h4
`define FXS_CODE_CONV  4'h6
`define FXS_CODE_OVF   4'h8
`define FXS_CODE_UNF   4'ha
`define FXS_CODE_UNDEF 4'hc
`define FXS_VECTOR     8'ha4
`define FXS_STEP_SGL   16'h0004
`define FXS_STEP_DBL   16'h0008
`define FXS_STEP_PTR   16'h0002
`define FXS_AC_MODE0_N 3'h6
`define FXS_AC_MEM_N   3'h4
`define FXS_EXP_MAX    10'h0ff
`define FXS_EXP_MIN    10'h001
`define FXS_SIGN       15
`define FXS_EXP_HI     14
`define FXS_EXP_LO     7
`define FXS_FRAC_DBL   56
`define FXS_FRAC_SGL   24
`define FXS_GUARD      2
`define FXS_WORDS      4
`endif

// ### include/fxs_pkg.sv
// Types of the float exception and status unit.
// Assumes fxs_cfg.svh on the include path.
`include "fxs_cfg.svh"
package fxs_pkg;
  // Operand addressing modes in encoding order
  typedef enum logic [2:0] {
    FXS_M_AC,
    FXS_M_DEF,
    FXS_M_AINC,
    FXS_M_AINCD,
    FXS_M_ADEC,
    FXS_M_ADECD,
    FXS_M_IDX,
    FXS_M_IDXD
  } fxs_mode_t;

  // Whole register state of the unit
  typedef struct packed {
    logic [15:0]           status;
    logic [3:0]            cause;
    logic [15:0]           epc;
    logic                  trap;
    logic [7:0]            vec;
    logic [15:0]           gpr;
    logic                  gpr_wr;
    logic                  res_valid;
    logic [0:`FXS_WORDS-1][15:0] res_w;
  } fxs_state_t;
endpackage

// ### rtl/fxs_round.sv
// Chop or round of a guarded fraction to single or double length.
// Assumes a normalised fraction, hidden bit at the top.
`timescale 1ns/1ps
`default_nettype none
`include "fxs_cfg.svh"
module fxs_round #(
  parameter int FW = `FXS_FRAC_DBL,
  parameter int GW = `FXS_GUARD,
  parameter int SW = `FXS_FRAC_SGL
) (
  input  wire logic [FW+GW-1:0] frac_in,
  input  wire logic             dbl,
  input  wire logic             chop,
  output logic      [FW-1:0]    frac_out,
  output logic                  carry
);
  localparam int DROP = FW - SW;

  logic [FW-1:0] keep;
  logic [FW-1:0] inc;
  logic          rnd;
  logic [FW:0]   sum;

  // Keep the format's bits, add one lsb when rounding and first dropped bit set
  always_comb begin
    keep = frac_in[FW+GW-1:GW];
    rnd  = frac_in[GW-1];
    inc  = {{(FW-1){1'b0}}, 1'b1};
    if (!dbl) begin
      keep = {frac_in[FW+GW-1:FW+GW-SW], {DROP{1'b0}}};
      rnd  = frac_in[FW+GW-SW-1];
      inc  = {{(SW-1){1'b0}}, 1'b1, {DROP{1'b0}}};
    end
    if (rnd && !chop) begin
      sum = {1'b0, keep} + {1'b0, inc};
    end else begin
      sum = {1'b0, keep};
    end
    carry    = sum[FW];
    frac_out = carry ? sum[FW:1] : sum[FW-1:0];
  end
endmodule // fxs_round
`default_nettype wire

// ### rtl/fxs_unit.sv
// Float status word, exception cause and pc capture, operand checks
// and result packing. Core microcode drives one op per op_valid pulse,
// all on ref_clk; results arrive in the cycle after the op.
`timescale 1ns/1ps
`default_nettype none
`include "fxs_cfg.svh"
module fxs_unit import fxs_pkg::*; #(
  parameter int FW = `FXS_FRAC_DBL,
  parameter int GW = `FXS_GUARD
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             op_valid,
  input  wire logic             op_illegal,
  input  wire logic [2:0]       op_mode,
  input  wire logic [2:0]       op_ac,
  input  wire logic             op_mem,
  input  wire logic             op_arith,
  input  wire logic             op_div,
  input  wire logic             op_conv,
  input  wire logic [15:0]      op_pc,
  input  wire logic [15:0]      src_hi,
  input  wire logic [15:0]      dst_hi,
  input  wire logic [15:0]      gpr_in,
  input  wire logic             res_sign,
  input  wire logic [9:0]       res_exp,
  input  wire logic [FW+GW-1:0] res_frac,
  input  wire logic             conv_carry,
  input  wire logic             conv_fail,
  input  wire logic             conv_zero,
  input  wire logic             load_status_op,
  input  wire logic [15:0]      load_data,
  output logic      [15:0]      status_word_reg,
  output logic      [3:0]       exception_cause_reg,
  output logic      [15:0]      exception_pc_reg,
  output logic                  trap_req,
  output logic      [7:0]       trap_vector,
  output logic      [15:0]      gpr_out,
  output logic                  gpr_wr,
  output logic                  res_valid,
  output logic      [15:0]      res_w0,
  output logic      [15:0]      res_w1,
  output logic      [15:0]      res_w2,
  output logic      [15:0]      res_w3
);
  fxs_state_t st;
  fxs_state_t next_st;

  // True when a word's biased exponent field is zero
  function automatic logic fxs_exp_zero(input logic [15:0] w);
    fxs_exp_zero = (w[`FXS_EXP_HI:`FXS_EXP_LO] == 8'h00);
  endfunction

  // Mode bits of the status word
  logic undefined_operand_irq_enable;
  logic underflow_irq_enable;
  logic overflow_irq_enable;
  logic conv_irq_enable;
  logic global_irq_disable;
  logic dbl;
  logic chop;
  assign undefined_operand_irq_enable = st.status[`FXS_B_UVEN];
  assign underflow_irq_enable         = st.status[`FXS_B_UNEN];
  assign overflow_irq_enable          = st.status[`FXS_B_OVEN];
  assign conv_irq_enable              = st.status[`FXS_B_ICEN];
  assign global_irq_disable           = st.status[`FXS_B_IDIS];
  assign dbl                          = st.status[`FXS_B_DBL];
  assign chop                         = st.status[`FXS_B_CHOP];

  // Chop or round the raw fraction
  logic [FW-1:0] frac_r;
  logic          rcarry;
  fxs_round #(
    .FW (FW),
    .GW (GW)
  ) u_round (
    .frac_in  (res_frac),
    .dbl      (dbl),
    .chop     (chop),
    .frac_out (frac_r),
    .carry    (rcarry)
  );

  // Operand checks done before execution
  logic acc_bad;
  logic undef_hit;
  logic div_zero;
  logic dvd_zero;
  logic pre_exc;
  assign acc_bad   = op_illegal |
                     ((op_mode == 3'h0) ? (op_ac >= `FXS_AC_MODE0_N)
                                        : (op_mem && op_ac >= `FXS_AC_MEM_N));
  // Negative zero from memory only; accumulator operands never trap
  assign undef_hit = undefined_operand_irq_enable && op_arith &&
                     op_mode != 3'h0 && src_hi[`FXS_SIGN] && fxs_exp_zero(src_hi);
  assign div_zero  = op_div && fxs_exp_zero(src_hi);
  assign dvd_zero  = op_div && fxs_exp_zero(dst_hi);
  assign pre_exc   = acc_bad | undef_hit | div_zero;

  // Result exponent range checks after rounding carry
  logic signed [9:0] exp_r;
  logic        [7:0] exp_lo;
  logic              res_zero;
  logic              ovf;
  logic              unf;
  logic              conv_err;
  logic              store_zero;
  assign exp_r      = $signed(res_exp) + $signed({9'h000, rcarry});
  assign exp_lo     = exp_r[7:0];
  assign res_zero   = dvd_zero || (frac_r == '0);
  assign ovf        = !op_conv && !res_zero && exp_r > $signed(`FXS_EXP_MAX);
  assign unf        = !op_conv && !res_zero && exp_r < $signed(`FXS_EXP_MIN);
  assign conv_err   = op_conv && conv_fail;
  // Disabled overflow or underflow returns exact zero
  assign store_zero = res_zero | (ovf && !overflow_irq_enable) |
                      (unf && !underflow_irq_enable);

  // Exceptions that update cause and pc, and their code by priority
  logic       qualify;
  logic [3:0] cause_sel;
  assign qualify   = acc_bad | div_zero | undef_hit |
                     (conv_err && conv_irq_enable) |
                     (ovf && overflow_irq_enable) |
                     (unf && underflow_irq_enable);
  assign cause_sel = acc_bad   ? `FXS_CODE_OPC   :
                     undef_hit ? `FXS_CODE_UNDEF :
                     div_zero  ? `FXS_CODE_DIV0  :
                     conv_err  ? `FXS_CODE_CONV  :
                     (ovf && overflow_irq_enable) ? `FXS_CODE_OVF :
                     `FXS_CODE_UNF;

  // Stored value: sign, low exponent byte, fraction without hidden bit
  logic [`FXS_WORDS*16-1:0] packed_res;
  assign packed_res = {res_sign, exp_lo, frac_r[FW-2:0]};

  // Address register step for the auto modes
  logic [15:0] step_sz;
  assign step_sz = dbl ? `FXS_STEP_DBL : `FXS_STEP_SGL;

  // Next state of the whole unit
  always_comb begin
    next_st           = st;
    next_st.trap      = 1'b0;
    next_st.gpr_wr    = 1'b0;
    next_st.res_valid = 1'b0;
    next_st.vec       = `FXS_VECTOR;
    if (load_status_op) begin
      next_st.status = load_data & `FXS_STAT_WMASK;
    end
    if (op_valid) begin
      // Cause and pc only move on a qualifying exception
      if (qualify) begin
        next_st.cause               = cause_sel;
        next_st.epc                 = op_pc;
        next_st.status[`FXS_B_ERR]  = 1'b1;
        next_st.trap                = !global_irq_disable;
      end
      if (!pre_exc) begin
        if (op_conv) begin
          next_st.status[`FXS_B_NEG]   = res_sign && !conv_zero && !conv_fail;
          next_st.status[`FXS_B_ZERO]  = conv_zero || conv_fail;
          next_st.status[`FXS_B_OVF]   = 1'b0;
          next_st.status[`FXS_B_CARRY] = conv_carry;
        end else begin
          next_st.status[`FXS_B_NEG]   = res_sign && !store_zero;
          next_st.status[`FXS_B_ZERO]  = store_zero;
          next_st.status[`FXS_B_OVF]   = ovf;
          next_st.status[`FXS_B_CARRY] = 1'b0;
          next_st.res_valid            = 1'b1;
          // Word 0 holds the most significant part, lowest address
          next_st.res_w = store_zero ? '0 : packed_res;
        end
        // Register side effects of the addressing mode
        unique case (fxs_mode_t'(op_mode))
          FXS_M_AINC: begin
            next_st.gpr    = gpr_in + step_sz;
            next_st.gpr_wr = 1'b1;
          end
          FXS_M_AINCD: begin
            next_st.gpr    = gpr_in + `FXS_STEP_PTR;
            next_st.gpr_wr = 1'b1;
          end
          FXS_M_ADEC: begin
            next_st.gpr    = gpr_in - step_sz;
            next_st.gpr_wr = 1'b1;
          end
          FXS_M_ADECD: begin
            next_st.gpr    = gpr_in - `FXS_STEP_PTR;
            next_st.gpr_wr = 1'b1;
          end
          FXS_M_AC, FXS_M_DEF, FXS_M_IDX, FXS_M_IDXD: begin
            next_st.gpr = st.gpr;
          end
        endcase
      end
    end
  end

  // State register; cause and pc clear on reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.status    <= `FXS_STAT_RST;
      st.cause     <= `FXS_CAUSE_RST;
      st.epc       <= `FXS_PC_RST;
      st.vec       <= `FXS_VECTOR;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state; cause and pc have no write input
  assign status_word_reg     = st.status;
  assign exception_cause_reg = st.cause;
  assign exception_pc_reg    = st.epc;
  assign trap_req            = st.trap;
  assign trap_vector         = st.vec;
  assign gpr_out             = st.gpr;
  assign gpr_wr              = st.gpr_wr;
  assign res_valid           = st.res_valid;
  assign res_w0              = st.res_w[0];
  assign res_w1              = st.res_w[1];
  assign res_w2              = st.res_w[2];
  assign res_w3              = st.res_w[3];

  // Checks on the unit's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_op_ok;
    op_valid && !pre_exc;
  endsequence
  sequence s_div0;
    op_valid && div_zero && !acc_bad && !undef_hit;
  endsequence
  sequence s_qual;
    op_valid && qualify;
  endsequence

  a_neg_flag: assert property (s_op_ok ##0 !op_conv |=>
    status_word_reg[`FXS_B_NEG] == res_w0[`FXS_SIGN])
    else $error("negative flag disagrees with stored sign");
  // A wrapped exponent may read zero on an enabled overflow or underflow,
  // so the flag is held against the whole stored value instead
  a_zero_flag: assert property (res_valid && status_word_reg[`FXS_B_ZERO] |->
    {res_w0, res_w1, res_w2, res_w3} == 64'h0)
    else $error("zero flag set with a nonzero stored result");
  a_ovf_flag: assert property (s_op_ok ##0 ovf |=>
    status_word_reg[`FXS_B_OVF])
    else $error("overflow flag not set");
  a_carry_flag: assert property (s_op_ok ##0 !op_conv |=>
    !status_word_reg[`FXS_B_CARRY])
    else $error("carry flag set outside conversion");
  a_trap_vec: assert property (s_qual |=>
    trap_req == !$past(global_irq_disable) && trap_vector == `FXS_VECTOR)
    else $error("trap pulse or vector wrong");
  a_div_cause: assert property (s_div0 |=>
    exception_cause_reg == `FXS_CODE_DIV0 && exception_pc_reg == $past(op_pc))
    else $error("divide by zero not recorded");
  a_cause_hold: assert property (op_valid && !qualify |=>
    $stable(exception_cause_reg) && $stable(exception_pc_reg))
    else $error("cause or pc moved without exception");
  a_ovf_masked: assert property (s_op_ok ##0 ovf && !overflow_irq_enable |=>
    $stable(exception_cause_reg) && res_w0 == 16'h0000)
    else $error("masked overflow updated cause or stored nonzero");
  a_fid_update: assert property (s_div0 ##0 global_irq_disable |=>
    !trap_req && exception_pc_reg == $past(op_pc))
    else $error("global disable blocked update or let trap out");
  a_acc_limit: assert property (op_valid && op_mode == 3'h0 && op_ac >= 3'h6 |=>
    exception_cause_reg == `FXS_CODE_OPC)
    else $error("accumulator 6 or 7 not refused");
  a_step_size: assert property (s_op_ok ##0 op_mode == 3'h2 |=>
    gpr_wr && gpr_out == $past(gpr_in) + $past(step_sz))
    else $error("auto increment step wrong");
  a_exp_wrap: assert property (s_op_ok ##0 ovf && overflow_irq_enable |=>
    res_w0[`FXS_EXP_HI:`FXS_EXP_LO] == $past(exp_lo) && res_valid)
    else $error("overflow exponent not wrapped");
  a_err_sticky: assert property (status_word_reg[`FXS_B_ERR] && !load_status_op |=>
    status_word_reg[`FXS_B_ERR])
    else $error("error flag cleared by hardware");
  a_err_set: assert property (s_qual |=>
    status_word_reg[`FXS_B_ERR] ##1 status_word_reg[`FXS_B_ERR] || $past(load_status_op))
    else $error("error flag not set on exception");
endmodule // fxs_unit
`default_nettype wire

// ### dv/fxs_core_model.sv
// Core-side partner of the float exception unit: holds the general
// register that the unit steps, stores result words in memory order
// and counts traps taken through the shared vector.
// Assumes the result and trap ports of fxs_unit on ref_clk and rstn.
`timescale 1ns/1ps
`default_nettype none
module fxs_core_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        gpr_wr,
  input  wire logic [15:0] gpr_out,
  input  wire logic        res_valid,
  input  wire logic [15:0] res_w0,
  input  wire logic [15:0] res_w1,
  input  wire logic [15:0] res_w2,
  input  wire logic [15:0] res_w3,
  input  wire logic        trap_req,
  input  wire logic [7:0]  trap_vector,
  output logic      [15:0] gpr_in,
  output int               traps
);
  logic [15:0] mem [4];

  // Register write-back, result store and trap log
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gpr_in <= 16'h1000;
      traps  <= 0;
    end else begin
      if (gpr_wr) begin
        gpr_in <= gpr_out;
      end
      // Most significant word lands at the lowest address
      if (res_valid) begin
        mem[0] <= res_w0;
        mem[1] <= res_w1;
        mem[2] <= res_w2;
        mem[3] <= res_w3;
      end
      // Only the shared float vector is taken
      if (trap_req && trap_vector == 8'ha4) begin
        traps <= traps + 1;
      end
    end
  end
endmodule // fxs_core_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the float exception and status unit.
// Assumes fxs_pkg, fxs_unit and fxs_core_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk, rstn, op_valid, op_illegal, op_mem, op_arith, op_div, op_conv;
  logic        res_sign, conv_carry, conv_fail, conv_zero, load_status_op, ovf, unf, zr;
  logic [2:0]  op_mode, op_ac, m;
  logic [3:0]  cause_e;
  logic [15:0] op_pc, src_hi, dst_hi, load_data, st, pc_e, ge, stp;
  logic [9:0]  res_exp;
  logic [57:0] res_frac;
  logic [73:0] pk;
  logic [63:0] we;
  logic [31:0] seed, r, v;
  int          errors = 0, samples_checked = 0, ntrap = 0, traps;
  wire  logic [15:0] gpr_in, status_word_reg, exception_pc_reg, gpr_out;
  wire  logic [15:0] res_w0, res_w1, res_w2, res_w3;
  wire  logic [3:0]  exception_cause_reg;
  wire  logic [7:0]  trap_vector;
  wire  logic        trap_req, gpr_wr, res_valid;

  fxs_unit uut (
    .ref_clk, .rstn, .op_valid, .op_illegal, .op_mode, .op_ac, .op_mem, .op_arith,
    .op_div, .op_conv, .op_pc, .src_hi, .dst_hi, .gpr_in, .res_sign, .res_exp,
    .res_frac, .conv_carry, .conv_fail, .conv_zero, .load_status_op, .load_data,
    .status_word_reg, .exception_cause_reg, .exception_pc_reg, .trap_req,
    .trap_vector, .gpr_out, .gpr_wr, .res_valid, .res_w0, .res_w1, .res_w2, .res_w3
  );
  fxs_core_model core (
    .ref_clk, .rstn, .gpr_wr, .gpr_out, .res_valid, .res_w0, .res_w1, .res_w2,
    .res_w3, .trap_req, .trap_vector, .gpr_in, .traps
  );

  // Clock at 50 MHz
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected exponent after rounding, then the four stored words
  function automatic logic [73:0] pack(logic s, logic [9:0] e, logic [57:0] f,
                                       logic d, logic c);
    logic [56:0] q;
    if (d) q = {1'b0, f[57:2]} + {56'h0, !c & f[1]};
    else q = {1'b0, f[57:34], 32'h0} + {24'h0, !c & f[33], 32'h0};
    if (q[56]) begin
      q = q >> 1;
      e = e + 10'h001;
    end
    return {e, s, e[7:0], q[54:0]};
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string t);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, t, g, e);
    end
  endtask

  // Idle values for every op input except op_pc
  task automatic clr();
    {op_valid, op_illegal, op_mem, op_arith, op_div, op_conv} = '0;
    {res_sign, conv_carry, conv_fail, conv_zero, load_status_op} = '0;
    {op_mode, op_ac} = '0;
    src_hi = 16'h4080;
    dst_hi = 16'h4080;
    res_exp = 10'h081;
    res_frac = {1'b1, 57'h0};
    load_data = '0;
  endtask

  task automatic ld(input logic [15:0] d);
    load_data = d;
    load_status_op = 1'b1;
    @(negedge ref_clk);
    load_status_op = 1'b0;
    st = d & 16'hcfef;
    chk(status_word_reg, st, "load");
    chk(exception_cause_reg, cause_e, "keep");
  endtask

  // One op; code 0 means cause and pc must hold
  task automatic run(input logic [3:0] code);
    v = rnd();
    op_pc = v[15:0];
    op_valid = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    if (code != 4'h0) begin
      cause_e = code;
      pc_e = op_pc;
      st[15] = 1'b1;
      if (!st[14]) ntrap++;
    end
    chk(exception_cause_reg, cause_e, "cause");
    chk(exception_pc_reg, pc_e, "pc");
    chk(status_word_reg, st, "status");
    chk(trap_req, code != 4'h0 && !st[14], "trap");
    clr();
  endtask

  task automatic end_sim();
    $display("Checked %0d values, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    end_sim();
  end

  // Directed corner cases, then random float ops
  initial begin
    seed = 32'hf11f;
    {cause_e, pc_e, st} = '0;
    rstn = 1'b0;
    clr();
    repeat (2) @(negedge ref_clk);
    chk({status_word_reg, exception_cause_reg, exception_pc_reg, trap_vector},
        {36'h0, 8'ha4}, "reset");
    rstn = 1'b1;
    ld(16'h0000);
    op_illegal = 1'b1;
    run(4'h2);
    op_ac = 3'd6;
    run(4'h2);
    op_ac = 3'd7;
    run(4'h2);
    op_ac = 3'd5;
    run(4'h0);
    op_mode = 3'd2;
    op_mem = 1'b1;
    op_ac = 3'd4;
    run(4'h2);
    op_div = 1'b1;
    src_hi = 16'h0000;
    run(4'h4);
    op_div = 1'b1;
    dst_hi = 16'h0000;
    st[3:0] = 4'h4;
    run(4'h0);
    chk({res_w0, res_w1, res_w2, res_w3}, 64'h0, "zero");
    for (int k = 0; k < 2; k++) begin
      ld(k ? 16'h0000 : 16'h0800);
      op_arith = 1'b1;
      op_mode = 3'd1;
      src_hi = 16'h8000;
      run(k ? 4'h0 : 4'hc);
    end
    for (int k = 0; k < 2; k++) begin
      ld(k ? 16'h0000 : 16'h0100);
      op_conv = 1'b1;
      conv_fail = 1'b1;
      st[3:0] = 4'h4;
      run(k ? 4'h0 : 4'h6);
    end
    ld(16'h0000);
    op_conv = 1'b1;
    conv_carry = 1'b1;
    st[3:0] = 4'h1;
    run(4'h0);
    chk(res_valid, 1'b0, "conv");
    ld(16'h4000);
    op_div = 1'b1;
    src_hi = 16'h0000;
    run(4'h4);
    ld(16'hffff);
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      ld(r[15:0]);
      v = rnd();
      op_arith = 1'b1;
      op_mode = r[18:16];
      m = r[18:16];
      op_ac = {1'b0, r[20:19]};
      src_hi = v[31:16] | 16'h0080;
      res_sign = r[21];
      res_exp = v[9:0];
      if (res_exp[7:0] == 8'h00) res_exp[0] = 1'b1;
      res_frac = {2'b10, rnd(), v[31:8]};
      pk = pack(res_sign, res_exp, res_frac, st[7], st[5]);
      ovf = $signed(pk[73:64]) > 255;
      unf = $signed(pk[73:64]) < 1;
      zr = (ovf && !st[9]) || (unf && !st[10]);
      we = zr ? 64'h0 : pk[63:0];
      st[3:0] = {res_sign && !zr, zr, ovf, 1'b0};
      stp = m[0] ? 16'h0002 : (st[7] ? 16'h0008 : 16'h0004);
      ge = m[2] ? gpr_in - stp : gpr_in + stp;
      run((ovf && st[9]) ? 4'h8 : ((unf && st[10]) ? 4'ha : 4'h0));
      chk(res_valid, 1'b1, "valid");
      chk({res_w0, res_w1, res_w2, res_w3}, we, "words");
      chk(gpr_wr, m inside {[3'd2:3'd5]}, "step");
      if (gpr_wr === 1'b1) chk(gpr_out, ge, "gpr");
    end
    @(negedge ref_clk);
    chk({core.mem[0], core.mem[1], core.mem[2], core.mem[3]}, we, "mem");
    chk(traps, ntrap, "traps");
    rstn = 1'b0;
    @(negedge ref_clk);
    chk({status_word_reg, exception_cause_reg, exception_pc_reg, trap_vector},
        {36'h0, 8'ha4}, "rerun");
    rstn = 1'b1;
    end_sim();
  end
endmodule // tb
`default_nettype wire
